// ---- src/ssr_pkg.sv ----
// Purpose: Shared constants and helpers for the serial command responder.
// Assumes: Byte-wide link, one parity bit per byte, 200 MHz clock.
// Notes:   Millisecond timing is counted in ticks from a clock divider.
package ssr_pkg;
  localparam logic [7:0] SOH      = 8'h01;
  localparam logic [7:0] STX      = 8'h02;
  localparam logic [7:0] ETX      = 8'h03;
  localparam logic [7:0] EOT      = 8'h04;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] CODE_OK  = 8'h41;
  localparam logic [7:0] CODE_PAR = 8'h42;
  localparam logic [7:0] CODE_CHK = 8'h43;
  localparam logic [7:0] CODE_CHR = 8'h44;
  localparam logic [7:0] CODE_CMD = 8'h45;
  localparam logic [7:0] CODE_DNO = 8'h46;
  localparam logic [7:0] CMD_STAT = 8'h01;
  localparam logic [7:0] CMD_GRP  = 8'h04;
  localparam logic [7:0] CMD_VAL  = 8'h05;
  localparam logic [7:0] CMD_UPL  = 8'h06;
  localparam logic [7:0] CMD_LOL  = 8'h07;
  localparam logic [7:0] CMD_ABBR = 8'h08;
  localparam logic [7:0] CMD_WEN  = 8'h09;
  localparam logic [7:0] CMD_IO   = 8'h12;
  localparam logic [7:0] CMD_GSEL = 8'h85;
  localparam logic [7:0] DNO_GRP  = 8'h01;
  localparam logic [7:0] DNO_GSEL = 8'h00;
  localparam logic [3:0] STAT_LAST = 4'hE;
  localparam logic [3:0] STAT_NAME = 4'h0;
  localparam logic [3:0] STAT_VAL  = 4'h8;
  localparam logic [7:0] IO_IN_DEV  = 8'h00;
  localparam logic [7:0] IO_IN_PIN  = 8'h40;
  localparam logic [7:0] IO_IN_COM  = 8'h60;
  localparam logic [7:0] IO_OUT_DEV = 8'h80;
  localparam logic [7:0] IO_OUT_PIN = 8'hC0;
  localparam logic [4:0] LEN_NAME = 5'h10;
  localparam logic [4:0] LEN_VAL  = 5'h0C;
  localparam logic [4:0] LEN_CODE = 5'h04;
  localparam logic [4:0] LEN_WORD = 5'h08;
  localparam logic [4:0] LEN_GSEL = 5'h04;
  localparam logic [4:0] TX_HDR   = 5'h03;
  localparam logic [4:0] MTX_HDR  = 5'h07;
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / MS_PER_S;
  localparam logic [10:0] INIT_MS = 11'd1000;
  localparam logic [10:0] TOUT_MS = 11'd300;
  localparam logic [10:0] GAP_MS  = 11'd100;
  localparam logic [1:0]  RETRY_MAX = 2'd3;
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;
  typedef enum logic [1:0] {ERR_NONE, ERR_TOUT, ERR_NEG, ERR_CHK} ssr_err_t;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? CH_0 + {4'h0, n} : CH_A + {4'h0, n} - 8'h0A;
  endfunction : hex_char

  // Bit 4 flags a character that is not an upper-case hex digit.
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= CH_0 && c < CH_0 + 8'h0A) hex_val = {1'b0, 4'(c - CH_0)};
    else if (c >= CH_A && c < CH_A + 8'h06)
      hex_val = {1'b0, 4'(c - CH_A + 8'h0A)};
    else hex_val = 5'h10;
  endfunction : hex_val

  function automatic logic [7:0] station_char(input logic [4:0] s);
    station_char = (s < 5'd10) ? CH_0 + {3'h0, s}
                               : CH_A + {3'h0, s} - 8'h0A;
  endfunction : station_char

  function automatic logic parity(input logic [7:0] b);
    parity = ^b;
  endfunction : parity
endpackage : ssr_pkg

// ---- src/ssr_link_if.sv ----
// Purpose: Byte link between the master end and the slave end.
// Assumes: Both ends run on the same clock.
// Notes:   The slave-to-master direction has no back-pressure.
`timescale 1ns/1ps
interface ssr_link_if;
  logic       m_valid;
  logic       m_ready;
  logic [7:0] m_data;
  logic       m_par;
  logic       s_valid;
  logic [7:0] s_data;
  logic       s_par;
  modport master (output m_valid, m_data, m_par,
                  input  m_ready, s_valid, s_data, s_par);
  modport slave  (input  m_valid, m_data, m_par,
                  output m_ready, s_valid, s_data, s_par);
endinterface : ssr_link_if

// ---- src/ssr_fifo.sv ----
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   Full and empty are registered flags.
`timescale 1ns/1ps
module ssr_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push, pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_reg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      cnt_reg   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg   <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      in_ready  <= (cnt_reg + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(D);
      out_valid <= (cnt_reg + (AW+1)'(push) - (AW+1)'(pop)) != '0;
    end
  end
endmodule : ssr_fifo

// ---- src/ssr_slave.sv ----
// Purpose: Slave end; parses framed read commands and sends replies.
// Assumes: User logic answers q_char in the same cycle from the q_ outputs.
// Notes:   Received bytes pass a 16-entry FIFO that back-pressures the link.
`timescale 1ns/1ps
module ssr_slave #(
  parameter int CLK_PER_MS = ssr_pkg::CLK_PER_MS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ssr_link_if.slave       lnk,
  input  wire logic [4:0] station,
  input  wire logic       alarm,
  input  wire logic       wr_forbid,
  input  wire logic [7:0] q_char,
  output logic [7:0]      q_cmd,
  output logic [7:0]      q_sel,
  output logic [1:0]      q_group,
  output logic [3:0]      q_idx,
  output logic            init_done
);
  import ssr_pkg::*;
  typedef enum {P_SOH, P_ST, P_C1, P_C0, P_STX, P_D1, P_D0, P_DATA,
                P_K1, P_K0, P_HOLD, P_TX} ssr_pst_t;
  ssr_pst_t         st_reg;
  logic [8:0]       f_data;
  logic             f_valid, f_ready, rx;
  logic [7:0]       b, code_reg, sum_reg, chk_reg, tx_char;
  logic [4:0]       hv, dlen_reg, tx_idx_reg;
  logic             mine_reg, perr_reg, cerr_reg;
  logic [1:0]       arg_reg;
  logic [31:0]      div_reg;
  logic [10:0]      ms_reg;
  logic             tick;
  ssr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (lnk.m_valid),
    .in_ready  (lnk.m_ready),
    .in_data   ({lnk.m_par, lnk.m_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_ready = (st_reg != P_HOLD) && (st_reg != P_TX);
  assign rx      = f_valid && f_ready;
  assign b       = f_data[7:0];
  assign hv      = hex_val(b);

  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = c inside {CMD_STAT, CMD_GRP, CMD_VAL, CMD_UPL, CMD_LOL,
                          CMD_ABBR, CMD_WEN, CMD_IO, CMD_GSEL};
  endfunction : cmd_known

  function automatic logic dno_ok(input logic [7:0] c, input logic [7:0] d);
    unique case (c)
      CMD_STAT: dno_ok = (d[7:4] == STAT_NAME || d[7:4] == STAT_VAL) &&
                         d[3:0] <= STAT_LAST;
      CMD_GRP:  dno_ok = d == DNO_GRP;
      CMD_IO:   dno_ok = d inside {IO_IN_DEV, IO_IN_PIN, IO_IN_COM,
                                   IO_OUT_DEV, IO_OUT_PIN};
      CMD_GSEL: dno_ok = d == DNO_GSEL;
      default:  dno_ok = 1'b1;
    endcase
  endfunction : dno_ok

  function automatic logic [4:0] data_len(input logic [7:0] c,
                                          input logic [7:0] d);
    unique case (c)
      CMD_STAT: data_len = d[7] ? LEN_VAL : LEN_NAME;
      CMD_GRP, CMD_WEN: data_len = LEN_CODE;
      CMD_VAL, CMD_UPL, CMD_LOL, CMD_IO: data_len = LEN_WORD;
      CMD_ABBR: data_len = LEN_VAL;
      default:  data_len = '0;
    endcase
  endfunction : data_len

  // Power-on initialisation timer from a millisecond tick.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg   <= '0;
      ms_reg    <= '0;
      init_done <= 1'b0;
    end else begin
      tick_cnt: begin
        if (div_reg == 32'(CLK_PER_MS - 1)) div_reg <= '0;
        else div_reg <= div_reg + 32'd1;
      end
      if (tick && !init_done) begin
        ms_reg <= ms_reg + 11'd1;
        if (ms_reg == INIT_MS - 11'd1) init_done <= 1'b1;
      end
    end
  end
  assign tick = div_reg == 32'(CLK_PER_MS - 1);

  always_comb begin
    if (tx_idx_reg == 5'd0) tx_char = STX;
    else if (tx_idx_reg == 5'd1) tx_char = station_char(station);
    else if (tx_idx_reg == 5'd2)
      tx_char = code_reg | (alarm ? CASE_BIT : 8'h00);
    else if (tx_idx_reg < TX_HDR + dlen_reg) begin
      if (q_cmd == CMD_GRP)
        tx_char = (q_idx == 4'd3) ? hex_char({2'b00, q_group}) : CH_0;
      else if (q_cmd == CMD_WEN)
        tx_char = (q_idx == 4'd3) ? CH_0 + {7'h0, wr_forbid} : CH_0;
      else tx_char = q_char;
    end
    else if (tx_idx_reg == TX_HDR + dlen_reg) tx_char = ETX;
    else if (tx_idx_reg == TX_HDR + dlen_reg + 5'd1)
      tx_char = hex_char(sum_reg[7:4]);
    else tx_char = hex_char(sum_reg[3:0]);
  end

  // Frame parser and reply sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg     <= P_SOH;
      mine_reg   <= 1'b0;
      perr_reg   <= 1'b0;
      cerr_reg   <= 1'b0;
      sum_reg    <= '0;
      chk_reg    <= '0;
      code_reg   <= CODE_OK;
      dlen_reg   <= '0;
      arg_reg    <= '0;
      tx_idx_reg <= '0;
      q_cmd      <= '0;
      q_sel      <= '0;
      q_group    <= '0;
      q_idx      <= '0;
      lnk.s_valid <= 1'b0;
      lnk.s_data  <= '0;
      lnk.s_par   <= 1'b0;
    end else begin
      lnk.s_valid <= 1'b0;
      if (rx && b == SOH) begin
        st_reg   <= P_ST;
        sum_reg  <= '0;
        perr_reg <= f_data[8] != parity(b);
        cerr_reg <= 1'b0;
      end else if (rx && b == EOT) begin
        st_reg <= P_SOH;
      end else if (rx && st_reg != P_SOH) begin
        if (f_data[8] != parity(b)) perr_reg <= 1'b1;
        if (st_reg != P_K1 && st_reg != P_K0)
          sum_reg <= sum_reg + b;
        unique case (st_reg)
          P_ST:  begin
            mine_reg <= b == station_char(station);
            st_reg   <= P_C1;
          end
          P_C1:  begin
            q_cmd[7:4] <= hv[3:0];
            cerr_reg   <= cerr_reg | hv[4];
            st_reg     <= P_C0;
          end
          P_C0:  begin
            q_cmd[3:0] <= hv[3:0];
            cerr_reg   <= cerr_reg | hv[4];
            st_reg     <= P_STX;
          end
          P_STX: begin
            cerr_reg <= cerr_reg | (b != STX);
            st_reg   <= P_D1;
          end
          P_D1:  begin
            q_sel[7:4] <= hv[3:0];
            cerr_reg   <= cerr_reg | hv[4];
            st_reg     <= P_D0;
          end
          P_D0:  begin
            q_sel[3:0] <= hv[3:0];
            cerr_reg   <= cerr_reg | hv[4];
            st_reg     <= P_DATA;
          end
          P_DATA: begin
            if (b == ETX) st_reg <= P_K1;
            else arg_reg <= hv[1:0];
          end
          P_K1:  begin
            chk_reg[7:4] <= hv[3:0];
            st_reg       <= P_K0;
          end
          P_K0:  begin
            st_reg <= mine_reg ? P_HOLD : P_SOH;
            dlen_reg <= '0;
            if (perr_reg || f_data[8] != parity(b)) code_reg <= CODE_PAR;
            else if ({chk_reg[7:4], hv[3:0]} != sum_reg)
              code_reg <= CODE_CHK;
            else if (cerr_reg) code_reg <= CODE_CHR;
            else if (!cmd_known(q_cmd)) code_reg <= CODE_CMD;
            else if (!dno_ok(q_cmd, q_sel)) code_reg <= CODE_DNO;
            else begin
              code_reg <= CODE_OK;
              dlen_reg <= data_len(q_cmd, q_sel);
              if (q_cmd == CMD_GSEL) q_group <= arg_reg;
            end
          end
          default: st_reg <= P_SOH;
        endcase
      end else if (st_reg == P_HOLD && init_done) begin
        st_reg     <= P_TX;
        tx_idx_reg <= '0;
        q_idx      <= '0;
        sum_reg    <= '0;
      end else if (st_reg == P_TX) begin
        lnk.s_valid <= 1'b1;
        lnk.s_data  <= tx_char;
        lnk.s_par   <= parity(tx_char);
        if (tx_idx_reg != 5'd0 && tx_idx_reg <= TX_HDR + dlen_reg)
          sum_reg <= sum_reg + tx_char;
        if (tx_idx_reg >= TX_HDR) q_idx <= q_idx + 4'd1;
        tx_idx_reg <= tx_idx_reg + 5'd1;
        if (tx_idx_reg == TX_HDR + dlen_reg + 5'd2) st_reg <= P_SOH;
      end
    end
  end
endmodule : ssr_slave

// ---- src/ssr_master.sv ----
// Purpose: Master end; frames requests, times out, retries, reports.
// Assumes: Requests come from user logic on the same clock.
// Notes:   Reply data characters are passed on before the checksum check.
`timescale 1ns/1ps
module ssr_master #(
  parameter int CLK_PER_MS = ssr_pkg::CLK_PER_MS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ssr_link_if.master      lnk,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [4:0] req_station,
  input  wire logic [7:0] req_cmd,
  input  wire logic [7:0] req_dno,
  input  wire logic [1:0] req_arg,
  output logic            rsp_valid,
  output logic [7:0]      rsp_char,
  output logic            done,
  output logic [7:0]      done_code,
  output logic            err,
  output ssr_pkg::ssr_err_t err_kind
);
  import ssr_pkg::*;
  typedef enum {M_INIT, M_IDLE, M_TX, M_WAIT, M_EOT, M_GAP, M_RX,
                M_K1, M_K0} ssr_mst_t;
  ssr_mst_t    st_reg;
  logic [4:0]  stn_reg, idx_reg, dlen;
  logic [7:0]  cmd_reg, dno_reg, sum_reg, chk_reg, code_reg, ch;
  logic [1:0]  arg_reg, tout_reg, neg_reg, bad_reg;
  logic [31:0] div_reg;
  logic [10:0] ms_reg;
  logic        tick, take, perr_reg;
  logic [4:0]  rxn_reg;
  assign tick = div_reg == 32'(CLK_PER_MS - 1);
  assign take = !lnk.m_valid || lnk.m_ready;
  assign dlen = (cmd_reg == CMD_GSEL) ? LEN_GSEL : 5'd0;
  logic [4:0]  shv;
  assign shv  = hex_val(lnk.s_data);

  always_comb begin
    unique case (idx_reg)
      5'd0: ch = SOH;
      5'd1: ch = station_char(stn_reg);
      5'd2: ch = hex_char(cmd_reg[7:4]);
      5'd3: ch = hex_char(cmd_reg[3:0]);
      5'd4: ch = STX;
      5'd5: ch = hex_char(dno_reg[7:4]);
      5'd6: ch = hex_char(dno_reg[3:0]);
      default: begin
        if (idx_reg < MTX_HDR + dlen)
          ch = (idx_reg == MTX_HDR + dlen - 5'd1)
               ? hex_char({2'b00, arg_reg}) : CH_0;
        else if (idx_reg == MTX_HDR + dlen) ch = ETX;
        else if (idx_reg == MTX_HDR + dlen + 5'd1) ch = hex_char(sum_reg[7:4]);
        else ch = hex_char(sum_reg[3:0]);
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= M_INIT;
      ms_reg <= '0;
      {stn_reg, idx_reg, rxn_reg} <= '0;
      {cmd_reg, dno_reg, sum_reg, chk_reg, code_reg} <= '0;
      {arg_reg, tout_reg, neg_reg, bad_reg} <= '0;
      perr_reg    <= 1'b0;
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_char    <= '0;
      done        <= 1'b0;
      done_code   <= '0;
      err         <= 1'b0;
      err_kind    <= ERR_NONE;
      lnk.m_valid <= 1'b0;
      lnk.m_data  <= '0;
      lnk.m_par   <= 1'b0;
    end else begin
      done      <= 1'b0;
      err       <= 1'b0;
      rsp_valid <= 1'b0;
      if (tick) ms_reg <= ms_reg + 11'd1;
      unique case (st_reg)
        M_INIT: if (tick && ms_reg == INIT_MS - 11'd1) begin
          st_reg    <= M_IDLE;
          req_ready <= 1'b1;
        end
        M_IDLE: if (req_valid) begin
          req_ready <= 1'b0;
          stn_reg   <= req_station;
          cmd_reg   <= req_cmd;
          dno_reg   <= req_dno;
          arg_reg   <= req_arg;
          {tout_reg, neg_reg, bad_reg} <= '0;
          idx_reg   <= '0;
          sum_reg   <= '0;
          st_reg    <= M_TX;
        end
        M_TX: if (take) begin
          if (idx_reg == MTX_HDR + dlen + 5'd3) begin
            lnk.m_valid <= 1'b0;
            ms_reg      <= '0;
            st_reg      <= M_WAIT;
          end else begin
            lnk.m_valid <= 1'b1;
            lnk.m_data  <= ch;
            lnk.m_par   <= parity(ch);
            if (idx_reg != 5'd0 && idx_reg <= MTX_HDR + dlen)
              sum_reg <= sum_reg + ch;
            idx_reg <= idx_reg + 5'd1;
          end
        end
        M_WAIT: begin
          if (lnk.s_valid && lnk.s_data == STX) begin
            st_reg   <= M_RX;
            rxn_reg  <= '0;
            sum_reg  <= '0;
            perr_reg <= lnk.s_par != parity(lnk.s_data);
          end else if (tick && ms_reg == TOUT_MS - 11'd1) begin
            st_reg      <= M_EOT;
            tout_reg    <= tout_reg + 2'd1;
            lnk.m_valid <= 1'b1;
            lnk.m_data  <= EOT;
            lnk.m_par   <= parity(EOT);
          end
        end
        M_EOT: if (lnk.m_ready) begin
          lnk.m_valid <= 1'b0;
          ms_reg      <= '0;
          st_reg      <= M_GAP;
        end
        M_GAP: if (tout_reg == RETRY_MAX) begin
          st_reg    <= M_IDLE;
          req_ready <= 1'b1;
          err       <= 1'b1;
          err_kind  <= ERR_TOUT;
        end else if (tick && ms_reg == GAP_MS - 11'd1) begin
          st_reg  <= M_TX;
          idx_reg <= '0;
          sum_reg <= '0;
        end
        M_RX: if (lnk.s_valid) begin
          if (lnk.s_par != parity(lnk.s_data)) perr_reg <= 1'b1;
          sum_reg <= sum_reg + lnk.s_data;
          rxn_reg <= rxn_reg + 5'd1;
          if (lnk.s_data == ETX) st_reg <= M_K1;
          else if (rxn_reg == 5'd1) code_reg <= lnk.s_data;
          else if (rxn_reg > 5'd1) begin
            rsp_valid <= 1'b1;
            rsp_char  <= lnk.s_data;
          end
        end
        M_K1: if (lnk.s_valid) begin
          if (lnk.s_par != parity(lnk.s_data)) perr_reg <= 1'b1;
          chk_reg[7:4] <= shv[3:0];
          st_reg       <= M_K0;
        end
        M_K0: if (lnk.s_valid) begin
          idx_reg <= '0;
          sum_reg <= '0;
          st_reg  <= M_TX;
          if (perr_reg || lnk.s_par != parity(lnk.s_data) ||
              {chk_reg[7:4], shv[3:0]} != sum_reg) begin
            bad_reg <= bad_reg + 2'd1;
            if (bad_reg == RETRY_MAX - 2'd1) begin
              st_reg    <= M_IDLE;
              req_ready <= 1'b1;
              err       <= 1'b1;
              err_kind  <= ERR_CHK;
            end
          end else if ((code_reg | CASE_BIT) != (CODE_OK | CASE_BIT)) begin
            neg_reg <= neg_reg + 2'd1;
            if (neg_reg == RETRY_MAX - 2'd1) begin
              st_reg    <= M_IDLE;
              req_ready <= 1'b1;
              err       <= 1'b1;
              err_kind  <= ERR_NEG;
            end
          end else begin
            st_reg    <= M_IDLE;
            req_ready <= 1'b1;
            done      <= 1'b1;
            done_code <= code_reg;
          end
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end
endmodule : ssr_master

// ---- test/ssr_link_assertions.sv ----
// Purpose: Link checks for the serial command responder.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Sees only the link between the two ends.
`timescale 1ns/1ps
module ssr_link_assertions import ssr_pkg::*;
#(parameter int CLK_PER_MS = 4) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       m_valid,
  input wire logic       m_ready,
  input wire logic [7:0] m_data,
  input wire logic       m_par,
  input wire logic       s_valid,
  input wire logic [7:0] s_data,
  input wire logic       s_par
);
  int         cnt_reg;
  logic       in_reg;
  logic [7:0] sum_reg;
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Time since reset, and the sum of reply bytes after STX through ETX.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 0;
      in_reg  <= 1'b0;
    end else begin
      if (cnt_reg < 1000 * CLK_PER_MS) cnt_reg <= cnt_reg + 1;
      if (s_valid) in_reg <= s_data == STX || in_reg && s_data != ETX;
    end
    if (s_valid && (in_reg || s_data == STX))
      sum_reg <= (s_data == STX) ? 8'h00 : sum_reg + s_data;
  end
  property p_mpar; m_valid |-> m_par == ^m_data; endproperty
  a_mpar: assert property (p_mpar) else $error("m parity");
  property p_spar; s_valid |-> s_par == ^s_data; endproperty
  a_spar: assert property (p_spar) else $error("s parity");
  property p_hold;
    m_valid && !m_ready |=> $stable({m_valid, m_data}); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_stn; s_valid && s_data == STX |=> s_valid &&
    s_data inside {[8'h30:8'h39], [8'h41:8'h56]}; endproperty
  a_stn: assert property (p_stn) else $error("station");
  property p_code; s_valid && s_data == STX |-> ##2 s_valid &&
    (s_data | CASE_BIT) inside {[8'h61:8'h66]}; endproperty
  a_code: assert property (p_code) else $error("code");
  property p_sum; s_valid && s_data == ETX && in_reg |=> s_valid &&
    s_data == hx(sum_reg[7:4]) ##1 s_valid && s_data == hx(sum_reg[3:0]);
  endproperty
  a_sum: assert property (p_sum) else $error("checksum");
  property p_sini; s_valid |-> cnt_reg >= 999 * CLK_PER_MS; endproperty
  a_sini: assert property (p_sini) else $error("early reply");
  property p_mini; m_valid |-> cnt_reg >= 999 * CLK_PER_MS; endproperty
  a_mini: assert property (p_mini) else $error("early send");
  c_eot: cover property (m_valid && m_data == EOT);
  c_low: cover property (s_valid && s_data == 8'h61);
  c_neg: cover property (s_valid && s_data == CODE_CMD);
endmodule : ssr_link_assertions

// ---- test/servo_serial_command_responder_test.sv ----
// Purpose: Joins master and slave ends and checks read replies.
// Assumes: Millisecond count shortened to 4 clocks.
// Notes:   A model of the read tables predicts every positive reply.
`timescale 1ns/1ps
module servo_serial_command_responder_test;
  import ssr_pkg::*;
  localparam int CPM = 4;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        req_valid, req_ready, rsp_valid, done, err, alarm;
  logic        wr_forbid, init_done;
  logic [1:0]  req_arg, q_group, grp;
  logic [3:0]  q_idx;
  logic [4:0]  req_station, station;
  logic [7:0]  req_cmd, req_dno, rsp_char, done_code, q_cmd, q_sel;
  logic [7:0]  q_char, g_code, rq[$];
  logic [31:0] rs = 32'd46668;
  logic [23:0] tbl[15] = '{24'h010010, 24'h010E10, 24'h01800C,
    24'h018E0C, 24'h040104, 24'h050008, 24'h060008, 24'h070008,
    24'h08000C, 24'h090004, 24'h120008, 24'h124008, 24'h126008,
    24'h128008, 24'h12C008};
  ssr_err_t    err_kind, g_kind;
  int          n_fail, compares, cyc;
  ssr_link_if lnk();
  ssr_master #(.CLK_PER_MS(CPM)) ssr_master_i(.clk, .rst_n, .lnk,
    .req_valid, .req_ready, .req_station, .req_cmd, .req_dno, .req_arg,
    .rsp_valid, .rsp_char, .done, .done_code, .err, .err_kind);
  ssr_slave #(.CLK_PER_MS(CPM)) ssr_slave_i(.clk, .rst_n, .lnk,
    .station, .alarm, .wr_forbid, .q_char, .q_cmd, .q_sel, .q_group,
    .q_idx, .init_done);
  ssr_link_assertions #(.CLK_PER_MS(CPM)) ssr_link_assertions_i(.clk,
    .rst_n, .m_valid(lnk.m_valid), .m_ready(lnk.m_ready),
    .m_data(lnk.m_data), .m_par(lnk.m_par), .s_valid(lnk.s_valid),
    .s_data(lnk.s_data), .s_par(lnk.s_par));
  // Slave user side: data character i is 'G' plus i.
  assign q_char = 8'h47 + {4'h0, q_idx};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (rsp_valid) rq.push_back(rsp_char);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [7:0] ec(input logic [7:0] c, input int i);
    if (c != CMD_GRP && c != CMD_WEN) return 8'h47 + i[7:0];
    if (i < 3) return 8'h30;
    return 8'h30 + ((c == CMD_GRP) ? {6'h0, grp} : {7'h0, wr_forbid});
  endfunction : ec
  task automatic cmp_byte(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic run(input logic [4:0] st, input logic [7:0] c, d);
    rq.delete();
    {req_station, req_cmd, req_dno, req_arg} = {st, c, d, grp};
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    do @(posedge clk); while (done !== 1'b1 && err !== 1'b1);
    {g_code, g_kind} = {done_code, err_kind};
    @(negedge clk);
  endtask : run
  task automatic rd(input logic [7:0] c, d, input int len);
    run(station, c, d);
    cmp_byte(g_code, CODE_OK | (alarm ? CASE_BIT : 8'h00));
    cmp_byte(8'(rq.size()), 8'(len));
    foreach (rq[i]) cmp_byte(rq[i], ec(c, i));
  endtask : rd
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    logic [7:0] c, d;
    {req_valid, req_station, req_cmd, req_dno, req_arg} = '0;
    {alarm, wr_forbid, station, grp} = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rs = xs(rs);
    {station, wr_forbid, grp} = rs[7:0];
    rd(CMD_GSEL, DNO_GSEL, 0);
    cmp_byte({6'h0, q_group}, {6'h0, grp});
    cmp_byte({7'h0, init_done}, 8'h01);
    foreach (tbl[i]) begin
      rs = xs(rs);
      alarm = i[0];
      c = tbl[i][23:16];
      d = (c inside {[CMD_VAL:CMD_WEN]}) ? rs[7:0] : tbl[i][15:8];
      rd(c, d, tbl[i][7:0]);
      cmp_byte(q_cmd, c);
      if (c inside {[CMD_VAL:CMD_WEN]}) cmp_byte(q_sel, d);
    end
    run(station, 8'h33, 8'h10);
    cmp_byte({6'h0, g_kind}, {6'h0, ERR_NEG});
    run(station, CMD_STAT, 8'h0F);
    cmp_byte({6'h0, g_kind}, {6'h0, ERR_NEG});
    run(station ^ 5'h01, CMD_STAT, 8'h00);
    cmp_byte({6'h0, g_kind}, {6'h0, ERR_TOUT});
    rd(CMD_GRP, DNO_GRP, 4);
    stop_test();
  end
endmodule : servo_serial_command_responder_test
